/* src/fmeas_pkg.sv */
// Operation
// - Fabric-side transmit FIFO depth is 8, 16 or 32 words.
// - Transceiver-side transmit and receive FIFOs are 8 or 16 words deep.
// - Fabric-side receive FIFO depth is 8, 16 or 64 words.
// - Data-valid qualifier travels through the FIFOs with each word.
// - Pulse reflects distance between write and read counters, not transit time.
// - Each FIFO drives a pulse whose duty equals occupancy over depth.
// - Sampling clock up to 262 MHz; pulses are hardened to it inside.
package fmeas_pkg;

   // ***************************************************************
   // Datapath shape
   // ***************************************************************
   localparam int unsigned FMEAS_DW = 40;

   // Word with its data-valid qualifier
   typedef struct packed {
      logic                valid;
      logic [FMEAS_DW-1:0] data;
   } fmeas_beat_t;

   // One latency pulse for each FIFO
   typedef struct packed {
      logic tx_core;
      logic tx_pcs;
      logic rx_pcs;
      logic rx_core;
   } fmeas_pulse_t;

   // ***************************************************************
   // Depths and reset values
   // ***************************************************************
   localparam int unsigned TX_CORE_DEPTH_DEF = 8;
   localparam int unsigned TX_PCS_DEPTH_DEF  = 8;
   localparam int unsigned RX_PCS_DEPTH_DEF  = 8;
   localparam int unsigned RX_CORE_DEPTH_DEF = 8;
   localparam logic        SCLK_RST          = 1'b0;
   localparam fmeas_pulse_t PULSE_RST        = '0;

   // Depth sets that each FIFO position can take
   function automatic bit fmeas_depth_ok(input int unsigned d, input int unsigned big);
      fmeas_depth_ok = (d == 8) || (d == 16) || (big != 0 && d == big);
   endfunction : fmeas_depth_ok

endpackage : fmeas_pkg

/* src/fmeas_pcfifo.sv */
`timescale 1ns/1ns
module fmeas_pcfifo
   import fmeas_pkg::*;
#(
   parameter int unsigned DEPTH = 8
)(
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   // Write side
   input  wire logic                 wr_en,
   input  fmeas_pkg::fmeas_beat_t    wr_beat,
   output logic                      full,
   // Read side
   input  wire logic                 rd_en,
   output logic                      empty,
   output logic                      out_strobe,
   output fmeas_pkg::fmeas_beat_t    out_beat,
   // Occupancy measurement
   output logic                      latency_pulse
);
   import fmeas_pkg::*;

   localparam int unsigned AW = $clog2(DEPTH);

   // Pointer wrap and the duty ramp both need a power-of-two depth
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("fifo depth must be a power of two of at least 2");
   end

   // ***************************************************************
   // Storage and counters
   // ***************************************************************
   fmeas_beat_t mem [DEPTH];
   logic [AW:0]   wr_ptr_q;
   logic [AW:0]   wr_ptr_d;
   logic [AW:0]   rd_ptr_q;
   logic [AW:0]   rd_ptr_d;
   logic [AW:0]   occ;
   logic [AW-1:0] ramp_q;
   logic [AW-1:0] ramp_d;
   logic          pulse_q;
   logic          pulse_d;
   logic          strobe_q;
   logic          strobe_d;
   fmeas_beat_t   beat_q;
   fmeas_beat_t   beat_d;
   logic          do_wr;
   logic          do_rd;

   // Pointer distance is what the pulse measures
   assign occ   = wr_ptr_q - rd_ptr_q;
   // One slot kept for a word already in flight from upstream
   assign full  = (occ >= (AW+1)'(DEPTH - 1));
   assign empty = (occ == '0);
   // Writes stop only when every slot is taken: an inner hop may still
   // land one word after full rose, and that word must not be lost
   assign do_wr = wr_en & (occ != (AW+1)'(DEPTH));
   assign do_rd = rd_en & ~empty;

   // Next pointers, output register and duty ramp
   always_comb
   begin
      wr_ptr_d = do_wr ? wr_ptr_q + 1'b1 : wr_ptr_q;
      rd_ptr_d = do_rd ? rd_ptr_q + 1'b1 : rd_ptr_q;
      strobe_d = do_rd;
      beat_d   = beat_q;
      if (do_rd)
      begin
         beat_d = mem[rd_ptr_q[AW-1:0]];
      end
      else
      begin
         beat_d.valid = 1'b0;
      end
      ramp_d  = ramp_q + 1'b1;
      // High for occ out of every DEPTH cycles
      pulse_d = ({1'b0, ramp_q} < occ);
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         strobe_q <= 1'b0;
         beat_q   <= '0;
         ramp_q   <= '0;
         pulse_q  <= 1'b0;
      end
      else
      begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         strobe_q <= strobe_d;
         beat_q   <= beat_d;
         ramp_q   <= ramp_d;
         pulse_q  <= pulse_d;
      end
   end

   // Storage has no reset; only written words are ever read
   always_ff @(posedge core_clk)
   begin
      if (do_wr)
      begin
         mem[wr_ptr_q[AW-1:0]] <= wr_beat;
      end
   end

   assign out_strobe    = strobe_q;
   assign out_beat      = beat_q;
   assign latency_pulse = pulse_q;

endmodule : fmeas_pcfifo

/* src/fmeas_top.sv */
`timescale 1ns/1ns
module fmeas_top
   import fmeas_pkg::*;
#(
   parameter int unsigned TX_CORE_DEPTH = fmeas_pkg::TX_CORE_DEPTH_DEF,
   parameter int unsigned TX_PCS_DEPTH  = fmeas_pkg::TX_PCS_DEPTH_DEF,
   parameter int unsigned RX_PCS_DEPTH  = fmeas_pkg::RX_PCS_DEPTH_DEF,
   parameter int unsigned RX_CORE_DEPTH = fmeas_pkg::RX_CORE_DEPTH_DEF
)(
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   // Transmit entry from fabric
   input  wire logic                 tx_put,
   input  fmeas_pkg::fmeas_beat_t    tx_beat_in,
   output logic                      tx_ready,
   // Transmit exit toward the lane
   input  wire logic                 tx_take,
   output logic                      tx_strobe,
   output fmeas_pkg::fmeas_beat_t    tx_beat_out,
   // Receive entry from the lane
   input  wire logic                 rx_put,
   input  fmeas_pkg::fmeas_beat_t    rx_beat_in,
   output logic                      rx_ready,
   // Receive exit toward fabric
   input  wire logic                 rx_take,
   output logic                      rx_strobe,
   output fmeas_pkg::fmeas_beat_t    rx_beat_out,
   // Latency measurement
   input  wire logic                 latency_sclk,
   output fmeas_pkg::fmeas_pulse_t   latency_pulse
);
   import fmeas_pkg::*;

   // ***************************************************************
   // Depth checks
   // ***************************************************************
   if (!fmeas_depth_ok(TX_CORE_DEPTH, 32))
   begin : g_bad_txc
      $error("tx core fifo depth must be 8, 16 or 32");
   end
   if (!fmeas_depth_ok(TX_PCS_DEPTH, 0) || !fmeas_depth_ok(RX_PCS_DEPTH, 0))
   begin : g_bad_pcs
      $error("pcs fifo depth must be 8 or 16");
   end
   if (!fmeas_depth_ok(RX_CORE_DEPTH, 64))
   begin : g_bad_rxc
      $error("rx core fifo depth must be 8, 16 or 64");
   end

   // ***************************************************************
   // Two-stage transmit and receive datapaths
   // ***************************************************************
   fmeas_beat_t  txc_beat;
   fmeas_beat_t  rxp_beat;
   logic         txc_empty;
   logic         txc_strobe;
   logic         txp_full;
   logic         txp_empty;
   logic         rxp_empty;
   logic         rxp_strobe;
   logic         rxc_full;
   logic         rxc_empty;
   logic         txc_full;
   logic         rxp_full;
   wire fmeas_pulse_t raw_pulse;

   // Inner hops move a word whenever the next FIFO has room
   fmeas_pcfifo #(.DEPTH(TX_CORE_DEPTH)) u_tx_core (
      .core_clk      (core_clk),
      .rst_n         (rst_n),
      .wr_en         (tx_put & tx_ready),
      .wr_beat       (tx_beat_in),
      .full          (txc_full),
      .rd_en         (~txp_full),
      .empty         (txc_empty),
      .out_strobe    (txc_strobe),
      .out_beat      (txc_beat),
      .latency_pulse (raw_pulse.tx_core)
   );

   fmeas_pcfifo #(.DEPTH(TX_PCS_DEPTH)) u_tx_pcs (
      .core_clk      (core_clk),
      .rst_n         (rst_n),
      .wr_en         (txc_strobe),
      .wr_beat       (txc_beat),
      .full          (txp_full),
      .rd_en         (tx_take),
      .empty         (txp_empty),
      .out_strobe    (tx_strobe),
      .out_beat      (tx_beat_out),
      .latency_pulse (raw_pulse.tx_pcs)
   );

   fmeas_pcfifo #(.DEPTH(RX_PCS_DEPTH)) u_rx_pcs (
      .core_clk      (core_clk),
      .rst_n         (rst_n),
      .wr_en         (rx_put & rx_ready),
      .wr_beat       (rx_beat_in),
      .full          (rxp_full),
      .rd_en         (~rxc_full),
      .empty         (rxp_empty),
      .out_strobe    (rxp_strobe),
      .out_beat      (rxp_beat),
      .latency_pulse (raw_pulse.rx_pcs)
   );

   fmeas_pcfifo #(.DEPTH(RX_CORE_DEPTH)) u_rx_core (
      .core_clk      (core_clk),
      .rst_n         (rst_n),
      .wr_en         (rxp_strobe),
      .wr_beat       (rxp_beat),
      .full          (rxc_full),
      .rd_en         (rx_take),
      .empty         (rxc_empty),
      .out_strobe    (rx_strobe),
      .out_beat      (rx_beat_out),
      .latency_pulse (raw_pulse.rx_core)
   );

   // Ready toward each writer; a put while not ready is dropped
   assign tx_ready = ~txc_full;
   assign rx_ready = ~rxp_full;

   // ***************************************************************
   // Hardening to the sampling clock
   // ***************************************************************
   // The sampling clock is a foreign pin: two stages before any use,
   // a third stage only to find its rising edge.
   logic         sclk_s1_q;
   logic         sclk_s2_q;
   logic         sclk_s3_q;
   logic         sclk_rise;
   fmeas_pulse_t held_q;
   fmeas_pulse_t held_d;

   assign sclk_rise = sclk_s2_q & ~sclk_s3_q;

   // Pulses change only on a sampling edge, so fabric sees one steady
   // value per sampling period; edges closer than two core cycles merge
   always_comb
   begin
      held_d = held_q;
      if (sclk_rise)
      begin
         held_d = raw_pulse;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_s1_q <= SCLK_RST;
         sclk_s2_q <= SCLK_RST;
         sclk_s3_q <= SCLK_RST;
         held_q    <= PULSE_RST;
      end
      else
      begin
         sclk_s1_q <= latency_sclk;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
         held_q    <= held_d;
      end
   end

   assign latency_pulse = held_q;

endmodule : fmeas_top

/* tb/fmeas_asserts.sv */
`timescale 1ns/1ns
module fmeas_asserts
   import fmeas_pkg::*;
(
   // Clock and reset
   input wire logic               core_clk,
   input wire logic               rst_n,
   // Transfer ports
   input wire logic               tx_put,
   input wire logic               tx_ready,
   input wire logic               tx_take,
   input wire logic               tx_strobe,
   input fmeas_pkg::fmeas_beat_t  tx_beat_out,
   input wire logic               rx_put,
   input wire logic               rx_ready,
   input wire logic               rx_strobe,
   input fmeas_pkg::fmeas_beat_t  rx_beat_out,
   // Measurement
   input wire logic               latency_sclk,
   input fmeas_pkg::fmeas_pulse_t latency_pulse
);
   logic [4:0] sh_q, sh_d;
   logic [5:0] occ_q, occ_d;
   logic [3:0] idl_q, idl_d;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Words held; idle only ages on sclk rises, so a stale pulse is tolerated
   always_comb
   begin
      sh_d  = {sh_q[3:0], latency_sclk};
      occ_d = occ_q + 6'(tx_put & tx_ready) + 6'(rx_put & rx_ready)
              - 6'(tx_strobe) - 6'(rx_strobe);
      idl_d = (occ_q != 6'h00) ? 4'h0 : idl_q + 4'(sh_q[1:0] == 2'b01 && idl_q != 4'hF);
   end
   // History registers
   always_ff @(posedge core_clk or negedge rst_n)
      if (!rst_n)
         {sh_q, occ_q, idl_q} <= '0;
      else
         {sh_q, occ_q, idl_q} <= {sh_d, occ_d, idl_d};
   property p_tx_vld; !tx_strobe |-> !tx_beat_out.valid; endproperty
   a_tx_vld: assert property (p_tx_vld) else $error("tx valid idle");
   property p_rx_vld; !rx_strobe |-> !rx_beat_out.valid; endproperty
   a_rx_vld: assert property (p_rx_vld) else $error("rx valid idle");
   property p_tx_hold; !tx_strobe |-> $stable(tx_beat_out.data); endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("tx data moved");
   property p_tx_pop; tx_strobe |-> $past(tx_take); endproperty
   a_tx_pop: assert property (p_tx_pop) else $error("tx pop uncaused");
   property p_tx_fill; $fell(tx_ready) |-> $past(tx_put); endproperty
   a_tx_fill: assert property (p_tx_fill) else $error("tx fill uncaused");
   property p_rx_fill; $fell(rx_ready) |-> $past(rx_put); endproperty
   a_rx_fill: assert property (p_rx_fill) else $error("rx fill uncaused");
   property p_pls_hold; sh_q == 5'h00 |-> $stable(latency_pulse); endproperty
   a_pls_hold: assert property (p_pls_hold) else $error("pulse w/o sclk");
   property p_idle; idl_q >= 4'h4 |-> latency_pulse == '0; endproperty
   a_idle: assert property (p_idle) else $error("pulse when empty");
   c_strobe: cover property (tx_strobe && rx_strobe);
   c_full: cover property (!tx_ready && !rx_ready);
   c_pulse: cover property (latency_pulse.tx_core);
endmodule : fmeas_asserts
bind fmeas_top fmeas_asserts u_chk (.core_clk(core_clk), .rst_n(rst_n),
   .tx_put(tx_put), .tx_ready(tx_ready), .tx_take(tx_take), .tx_strobe(tx_strobe),
   .tx_beat_out(tx_beat_out), .rx_put(rx_put), .rx_ready(rx_ready),
   .rx_strobe(rx_strobe), .rx_beat_out(rx_beat_out),
   .latency_sclk(latency_sclk), .latency_pulse(latency_pulse));

/* tb/fmeas_accum.sv */
`timescale 1ns/1ns
module fmeas_accum
   import fmeas_pkg::*;
(
   // Sampling clock and reset
   input wire logic               latency_sclk,
   input wire logic               acc_rst_n,
   // Pulses in, sums out
   input fmeas_pkg::fmeas_pulse_t latency_pulse,
   output logic [8:0]             sum_q [4],
   output logic                   done_q
);
   logic [7:0] cnt_q, cnt_d;
   logic [8:0] sum_d [4];
   logic       done_d;
   // Sum each pulse for 128 edges, then freeze with the flag up
   always_comb
   begin
      cnt_d  = cnt_q;
      sum_d  = sum_q;
      done_d = 1'b1;
      if (cnt_q < 8'h80)
      begin
         cnt_d  = cnt_q + 8'h01;
         done_d = 1'b0;
         for (int i = 0; i < 4; i++)
            sum_d[i] = sum_q[i] + 9'(latency_pulse[i]);
      end
   end
   // Reset clears everything; device hardens the pulses
   always_ff @(posedge latency_sclk or negedge acc_rst_n)
   begin
      if (!acc_rst_n)
      begin
         cnt_q  <= '0;
         sum_q  <= '{default: '0};
         done_q <= 1'b0;
      end
      else
      begin
         cnt_q  <= cnt_d;
         sum_q  <= sum_d;
         done_q <= done_d;
      end
   end
endmodule : fmeas_accum

/* tb/fmeas_top_tb.sv */
`timescale 1ns/1ns
module fmeas_top_tb;
   import fmeas_pkg::*;
   localparam int DEP = 8;
   logic         core_clk, rst_n, acc_rst_n, sclk_run, latency_sclk, done_q;
   logic         tx_put, tx_ready, tx_take, tx_strobe;
   logic         rx_put, rx_ready, rx_take, rx_strobe;
   fmeas_beat_t  tx_beat_in, tx_beat_out, rx_beat_in, rx_beat_out;
   fmeas_pulse_t latency_pulse;
   logic [8:0]   sum_q [4];
   int           compares, miscompares, a, b;
   // Core clock, and a 14 ns sampling clock that stands low when gated;
   // its edges fall on odd ns, never on a core edge, so no sampling race
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   initial
   begin
      latency_sclk = 1'b0;
      forever
      begin
         #3 latency_sclk = sclk_run;
         #6 latency_sclk = 1'b0;
         #5;
      end
   end
   fmeas_top #(.TX_CORE_DEPTH(DEP), .TX_PCS_DEPTH(DEP), .RX_PCS_DEPTH(DEP),
      .RX_CORE_DEPTH(DEP)) DUT (.core_clk(core_clk), .rst_n(rst_n),
      .tx_put(tx_put), .tx_beat_in(tx_beat_in), .tx_ready(tx_ready), .tx_take(tx_take),
      .tx_strobe(tx_strobe), .tx_beat_out(tx_beat_out), .rx_put(rx_put),
      .rx_beat_in(rx_beat_in), .rx_ready(rx_ready), .rx_take(rx_take),
      .rx_strobe(rx_strobe), .rx_beat_out(rx_beat_out),
      .latency_sclk(latency_sclk), .latency_pulse(latency_pulse));
   fmeas_accum ACC (.latency_sclk(latency_sclk), .acc_rst_n(acc_rst_n),
      .latency_pulse(latency_pulse), .sum_q(sum_q), .done_q(done_q));
   task automatic chk(input string w, input logic [40:0] e, input logic [40:0] g);
      compares++;
      if (g !== e)
      begin
         miscompares++;
         $display("MISMATCH %s exp %0h got %0h", w, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   // Put on both entries every cycle, exits stalled; count acceptances
   task automatic fill(input int lim, input logic v, output int nt, output int nr);
      {nt, nr, tx_take, rx_take} = '0;
      repeat (lim)
      begin
         {tx_put, rx_put} = 2'b11;
         tx_beat_in = {v, 40'(nt)};
         rx_beat_in = {v, 40'(nr)};
         nt += int'(tx_ready);
         nr += int'(rx_ready);
         cyc(1);
      end
      {tx_put, rx_put} = 2'b00;
   endtask : fill
   // Pop both exits back to back; order, qualifier and count
   task automatic drain(input int nt, input int nr, input logic v);
      int k, j;
      {k, j} = '0;
      {tx_take, rx_take} = 2'b11;
      repeat (50)
      begin
         cyc(1);
         if (tx_strobe === 1'b1)
            chk("tx out", {v, 40'(k++)}, tx_beat_out);
         if (rx_strobe === 1'b1)
            chk("rx out", {v, 40'(j++)}, rx_beat_out);
      end
      chk("tx cnt", 41'(nt), 41'(k));
      chk("rx cnt", 41'(nr), 41'(j));
   endtask : drain
   // Accumulate 128 samples with n words in each path
   task automatic meas(input int n);
      int i, e, t;
      {sclk_run, acc_rst_n, i, e, t} = {2'b10, 96'(0)};
      cyc(12);
      acc_rst_n = 1'b1;
      while (done_q !== 1'b1 && i++ < 600)
         cyc(1);
      chk("acc done", 41'h1, 41'(done_q));
      e = 128 * n / DEP;
      // Tx pcs FIFO holds all n words: depth times sum over 128, plus the
      // output register, times the faster period (the 4 ns core clock)
      t = (DEP * int'(sum_q[2]) + 64) / 128;
      chk("tx pcs delay", 41'(4 * (n + 1)), 41'(4 * (t + 1)));
      t = int'(sum_q[3]) + int'(sum_q[2]) - e;
      chk("tx duty", 41'h1, 41'(t >= -8 && t <= 8 && (n > 0 || t == 0)));
      t = int'(sum_q[1]) + int'(sum_q[0]) - e;
      chk("rx duty", 41'h1, 41'(t >= -8 && t <= 8 && (n > 0 || t == 0)));
   endtask : meas
   task automatic results;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results
   // Watchdog
   initial
   begin
      #20000;
      miscompares++;
      results;
   end
   // Main sequence
   initial
   begin
      {tx_put, tx_take, rx_put, rx_take, sclk_run, rst_n, acc_rst_n} = '0;
      {tx_beat_in, rx_beat_in, compares, miscompares} = '0;
      cyc(20);
      rst_n = 1'b1;
      cyc(2);
      drain(0, 0, 1'b0);
      fill(3, 1'b1, a, b);
      chk("pass", 41'h303, 41'({a[7:0], b[7:0]}));
      drain(3, 3, 1'b1);
      fill(24, 1'b0, a, b);
      chk("tx depth", 41'h1, 41'(a >= DEP - 1 && a <= 2 * DEP));
      chk("rx depth", 41'h1, 41'(b >= DEP - 1 && b <= 2 * DEP));
      drain(a, b, 1'b0);
      meas(0);
      fill(4, 1'b1, a, b);
      meas(4);
      drain(4, 4, 1'b1);
      cyc(10);
      sclk_run = 1'b0;
      fill(5, 1'b1, a, b);
      rst_n = 1'b0;
      cyc(2);
      chk("rst rdy", 41'h3, 41'({tx_ready, rx_ready}));
      rst_n = 1'b1;
      cyc(1);
      drain(0, 0, 1'b0);
      results;
   end
endmodule : fmeas_top_tb
